// ### logic/uer_params.svh
`ifndef UER_PARAMS_SVH
`define UER_PARAMS_SVH
// cpu-side locations
`define UER_OFF_ACCESS_CTL 8'he0
`define UER_OFF_POINTER 8'he1
`define UER_OFF_DATA 8'he2
// access control fields
`define UER_BIT_REGULATOR 7
`define UER_BIT_WSTROBE 1
`define UER_BIT_RSTROBE 0
// engine register offsets
`define UER_E_DEV_CTL 6'h01
`define UER_E_FUNC_ADDR 6'h08
`define UER_E_IRQ_EN 6'h10
`define UER_E_PWR_CTL 6'h12
`define UER_E_FUNC_IRQ_EN 6'h18
`define UER_E_FUNC_IRQ_FLAGS 6'h1a
`define UER_E_EP_CTL 6'h21
`define UER_E_RX_DATA 6'h23
`define UER_E_RX_CTL 6'h24
`define UER_E_RX_COUNT 6'h26
`define UER_E_EP_SELECT 6'h31
`define UER_E_TX_DATA 6'h33
`define UER_E_TX_CTL 6'h34
`define UER_E_TX_COUNT 6'h36
// device control fields and reset
`define UER_DEV_CTL_RESET 8'h01
`define UER_DEV_CTL_MASK 8'h87
`define UER_BIT_TEST_MODE 7
`define UER_BIT_EP3_DIR 2
`define UER_BIT_PULLUP 1
`define UER_BIT_CONNECT 0
// power control fields
`define UER_BIT_REMOTE_WAKE 5
`define UER_BIT_BUS_RESET 3
`define UER_BIT_RESUME 1
`define UER_BIT_SUSPEND 0
// interrupt enable fields
`define UER_BIT_EN_SUSP_RES 3
`define UER_BIT_EN_FUNC 1
`define UER_IRQ_EN_MASK 8'h8a
`define UER_FUNC_FLAG_MASK 8'h1f
`define UER_EP_CTL_MASK 8'hca
// fifo control fields
`define UER_BIT_FIFO_FLUSH 7
`define UER_BIT_FIFO_RELEASE 4
`endif

// ### logic/uer_pkg.sv
package uer_pkg;
  typedef logic [7:0] uer_byte_type;
  typedef logic [5:0] uer_eaddr_type;
  typedef logic [1:0] uer_ep_type;
  typedef logic [6:0] uer_func_addr_type;
  typedef logic [4:0] uer_done_type;
  typedef logic [3:0] uer_count_type;
endpackage

// ### logic/uer_top.sv
`timescale 1ns/1ps
`include "uer_params.svh"
// Function
// - access control bit 7 switches the 3.3V regulator on (1) or off (0).
// - pointer low six bits choose the engine register for indirect access.
// - one data location: writes feed engine writes, reads return fetched bytes.
// - pointer, set write strobe, store data, clear strobe performs engine write.
// - pointer, set read strobe, read data, clear strobe returns addressed register.
// - engine raises interrupt request on each completed transaction.
// - bus reset resets engine state and raises interrupt request.
// - host wake-up while suspended asserts oscillator enable.
// - port3 falling edge while suspended wakes the device for remote wake-up.
// - device control bit 2 makes endpoint 3 transmit (1) or receive (0).
// - device control bit 1 switches on the D- pull-up.
// - device control bit 0 resets to one; zero drives SE0 to disconnect.
// - seven-bit function address, cleared by system or bus reset.
// - power control bit 5 starts remote wake-up signalling on the bus.
// - hardware sets bus reset flag and interrupts; firmware clears it.
// - hardware sets resume flag and interrupts; firmware clears it.
// - hardware sets suspend flag and interrupts; firmware clears it.
// - endpoint select low bits pick endpoint 0-3 for indexed registers.
// - endpoint done flags readable, cleared by writing one.
module uer_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // cpu special function register port
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire uer_pkg::uer_byte_type cpu_wdata_i,
  output uer_pkg::uer_byte_type cpu_rdata_o,
  // engine events
  input wire uer_pkg::uer_done_type xact_done_i,
  input wire logic bus_reset_det_i,
  input wire logic resume_det_i,
  input wire logic suspend_det_i,
  input wire logic host_wakeup_i,
  input wire logic device_suspended_i,
  input wire logic port3_i,
  // engine fifo side
  input wire uer_pkg::uer_byte_type rx_fifo_data_i,
  input wire uer_pkg::uer_count_type rx_byte_count_i,
  output logic rx_fifo_pop_o,
  output logic rx_flush_o,
  output logic rx_release_o,
  output logic tx_flush_o,
  output logic tx_push_o,
  output uer_pkg::uer_byte_type tx_fifo_data_o,
  output logic tx_count_load_o,
  output uer_pkg::uer_count_type tx_byte_count_o,
  // device controls
  output logic regulator_enable_o,
  output logic test_mode_enable_o,
  output logic endpoint3_direction_o,
  output logic minus_line_pullup_enable_o,
  output logic connect_release_o,
  output uer_pkg::uer_func_addr_type function_address_o,
  output uer_pkg::uer_ep_type endpoint_select_o,
  output uer_pkg::uer_byte_type endpoint_control_o,
  output logic remote_wakeup_trigger_o,
  output logic osc_enable_o,
  output logic cpu_wake_o,
  output logic usb_irq_o
);
  import uer_pkg::*;

  logic rst_meta_reg;
  logic rst_n;
  logic port3_meta_reg;
  logic port3_sync_reg;
  logic port3_prev_reg;
  uer_byte_type access_ctl_reg;
  uer_eaddr_type pointer_reg;
  uer_byte_type read_data_reg;
  uer_byte_type dev_ctl_reg;
  uer_func_addr_type func_addr_reg;
  uer_byte_type irq_en_reg;
  uer_byte_type pwr_ctl_reg;
  uer_byte_type pwr_ctl_next;
  uer_byte_type func_irq_en_reg;
  uer_done_type flags_reg;
  uer_done_type flags_next;
  uer_ep_type ep_sel_reg;
  uer_byte_type ep_ctl_reg [0:3];
  uer_byte_type eng_rdata;
  uer_byte_type eng_wdata;
  logic ctl_wr;
  logic ptr_wr;
  logic eng_wr;
  logic rd_start;
  logic osc_reg;
  logic wake_reg;
  logic rx_pop_reg;
  logic rx_flush_reg;
  logic rx_rel_reg;
  logic tx_flush_reg;
  logic tx_push_reg;
  logic tx_cnt_reg;
  uer_byte_type tx_data_reg;
  uer_count_type tx_cnt_val_reg;

  function automatic logic eng_hit(input uer_eaddr_type a, input uer_eaddr_type off);
    eng_hit = (a == off);
  endfunction

  // reset release
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // port3 pin synchroniser
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      port3_meta_reg <= 1'b1;
      port3_sync_reg <= 1'b1;
      port3_prev_reg <= 1'b1;
    end else begin
      port3_meta_reg <= port3_i;
      port3_sync_reg <= port3_meta_reg;
      port3_prev_reg <= port3_sync_reg;
    end
  end

  assign ctl_wr = cpu_wr_i && (cpu_addr_i == `UER_OFF_ACCESS_CTL);
  assign ptr_wr = cpu_wr_i && (cpu_addr_i == `UER_OFF_POINTER);
  // write performed when data stored with write strobe up
  assign eng_wr = cpu_wr_i && (cpu_addr_i == `UER_OFF_DATA)
    && access_ctl_reg[`UER_BIT_WSTROBE];
  assign eng_wdata = cpu_wdata_i;
  // fetch starts on the rising read strobe
  assign rd_start = ctl_wr && cpu_wdata_i[`UER_BIT_RSTROBE]
    && !access_ctl_reg[`UER_BIT_RSTROBE];

  // access control and pointer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      access_ctl_reg <= 8'h00;
      pointer_reg <= 6'h00;
    end else begin
      if (ctl_wr) begin
        access_ctl_reg <= cpu_wdata_i & 8'h83;
      end
      if (ptr_wr) begin
        pointer_reg <= cpu_wdata_i[5:0];
      end
    end
  end

  assign regulator_enable_o = access_ctl_reg[`UER_BIT_REGULATOR];

  // fetched byte lands on the same edge that stores the read strobe
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      read_data_reg <= 8'h00;
    end else if (rd_start) begin
      read_data_reg <= eng_rdata;
    end
  end

  always_comb begin
    cpu_rdata_o = 8'h00;
    unique case (cpu_addr_i)
      `UER_OFF_ACCESS_CTL: cpu_rdata_o = access_ctl_reg;
      `UER_OFF_POINTER: cpu_rdata_o = {2'b00, pointer_reg};
      `UER_OFF_DATA: cpu_rdata_o = read_data_reg;
      default: cpu_rdata_o = 8'h00;
    endcase
  end

  // engine register read mux
  always_comb begin
    eng_rdata = 8'h00;
    unique case (pointer_reg)
      `UER_E_DEV_CTL: eng_rdata = dev_ctl_reg;
      `UER_E_FUNC_ADDR: eng_rdata = {1'b0, func_addr_reg};
      `UER_E_IRQ_EN: eng_rdata = irq_en_reg;
      `UER_E_PWR_CTL: eng_rdata = pwr_ctl_reg;
      `UER_E_FUNC_IRQ_EN: eng_rdata = func_irq_en_reg;
      `UER_E_FUNC_IRQ_FLAGS: eng_rdata = {3'b000, flags_reg};
      `UER_E_EP_CTL: eng_rdata = ep_ctl_reg[ep_sel_reg];
      `UER_E_RX_DATA: eng_rdata = rx_fifo_data_i;
      `UER_E_RX_COUNT: eng_rdata = {4'h0, rx_byte_count_i};
      `UER_E_EP_SELECT: eng_rdata = {6'h00, ep_sel_reg};
      default: eng_rdata = 8'h00;
    endcase
  end

  // device control, system reset only
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctl_reg <= `UER_DEV_CTL_RESET;
    end else if (eng_wr && eng_hit(pointer_reg, `UER_E_DEV_CTL)) begin
      dev_ctl_reg <= eng_wdata & `UER_DEV_CTL_MASK;
    end
  end

  assign test_mode_enable_o = dev_ctl_reg[`UER_BIT_TEST_MODE];
  assign endpoint3_direction_o = dev_ctl_reg[`UER_BIT_EP3_DIR];
  assign minus_line_pullup_enable_o = dev_ctl_reg[`UER_BIT_PULLUP];
  assign connect_release_o = dev_ctl_reg[`UER_BIT_CONNECT];

  // function address and endpoint select
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      func_addr_reg <= 7'h00;
      ep_sel_reg <= 2'b00;
    end else if (bus_reset_det_i) begin
      func_addr_reg <= 7'h00;
      ep_sel_reg <= 2'b00;
    end else if (eng_wr) begin
      if (eng_hit(pointer_reg, `UER_E_FUNC_ADDR)) begin
        func_addr_reg <= eng_wdata[6:0];
      end
      if (eng_hit(pointer_reg, `UER_E_EP_SELECT)) begin
        ep_sel_reg <= eng_wdata[1:0];
      end
    end
  end

  assign function_address_o = func_addr_reg;
  assign endpoint_select_o = ep_sel_reg;

  // indexed endpoint control
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        ep_ctl_reg[i] <= 8'h00;
      end
    end else if (bus_reset_det_i) begin
      for (int i = 0; i < 4; i++) begin
        ep_ctl_reg[i] <= 8'h00;
      end
    end else if (eng_wr && eng_hit(pointer_reg, `UER_E_EP_CTL)) begin
      ep_ctl_reg[ep_sel_reg] <= eng_wdata & `UER_EP_CTL_MASK;
    end
  end

  assign endpoint_control_o = ep_ctl_reg[ep_sel_reg];

  // interrupt enables
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= 8'h00;
      func_irq_en_reg <= 8'h00;
    end else begin
      if (bus_reset_det_i) begin
        func_irq_en_reg <= 8'h00;
      end else if (eng_wr && eng_hit(pointer_reg, `UER_E_FUNC_IRQ_EN)) begin
        func_irq_en_reg <= eng_wdata & `UER_FUNC_FLAG_MASK;
      end
      if (eng_wr && eng_hit(pointer_reg, `UER_E_IRQ_EN)) begin
        irq_en_reg <= eng_wdata & `UER_IRQ_EN_MASK;
      end
    end
  end

  // power flags: writing zero clears, a detect in the same cycle wins
  always_comb begin
    pwr_ctl_next = pwr_ctl_reg;
    if (eng_wr && eng_hit(pointer_reg, `UER_E_PWR_CTL)) begin
      pwr_ctl_next[`UER_BIT_REMOTE_WAKE] = eng_wdata[`UER_BIT_REMOTE_WAKE];
      pwr_ctl_next[`UER_BIT_BUS_RESET] = pwr_ctl_reg[`UER_BIT_BUS_RESET]
        & eng_wdata[`UER_BIT_BUS_RESET];
      pwr_ctl_next[`UER_BIT_RESUME] = pwr_ctl_reg[`UER_BIT_RESUME]
        & eng_wdata[`UER_BIT_RESUME];
      pwr_ctl_next[`UER_BIT_SUSPEND] = pwr_ctl_reg[`UER_BIT_SUSPEND]
        & eng_wdata[`UER_BIT_SUSPEND];
    end
    if (bus_reset_det_i) begin
      pwr_ctl_next = 8'h00;
      pwr_ctl_next[`UER_BIT_BUS_RESET] = 1'b1;
    end
    if (resume_det_i) begin
      pwr_ctl_next[`UER_BIT_RESUME] = 1'b1;
    end
    if (suspend_det_i) begin
      pwr_ctl_next[`UER_BIT_SUSPEND] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctl_reg <= 8'h00;
    end else begin
      pwr_ctl_reg <= pwr_ctl_next;
    end
  end

  assign remote_wakeup_trigger_o = pwr_ctl_reg[`UER_BIT_REMOTE_WAKE];

  // endpoint done flags, write one to clear, set wins
  always_comb begin
    flags_next = flags_reg;
    if (eng_wr && eng_hit(pointer_reg, `UER_E_FUNC_IRQ_FLAGS)) begin
      flags_next = flags_reg & ~eng_wdata[4:0];
    end
    if (bus_reset_det_i) begin
      flags_next = 5'h00;
    end
    flags_next = flags_next | xact_done_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 5'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign usb_irq_o = (irq_en_reg[`UER_BIT_EN_FUNC] && |(flags_reg & func_irq_en_reg[4:0]))
    || (irq_en_reg[`UER_BIT_EN_SUSP_RES] && (pwr_ctl_reg[`UER_BIT_BUS_RESET]
    || pwr_ctl_reg[`UER_BIT_RESUME] || pwr_ctl_reg[`UER_BIT_SUSPEND]));

  // wake-up signals
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      osc_reg <= device_suspended_i && host_wakeup_i;
      wake_reg <= device_suspended_i && port3_prev_reg && !port3_sync_reg;
    end
  end

  assign osc_enable_o = osc_reg;
  assign cpu_wake_o = wake_reg;

  // fifo side strobes
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_pop_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
      rx_rel_reg <= 1'b0;
      tx_flush_reg <= 1'b0;
      tx_push_reg <= 1'b0;
      tx_cnt_reg <= 1'b0;
    end else begin
      rx_pop_reg <= rd_start && eng_hit(pointer_reg, `UER_E_RX_DATA);
      rx_flush_reg <= eng_wr && eng_hit(pointer_reg, `UER_E_RX_CTL)
        && eng_wdata[`UER_BIT_FIFO_FLUSH];
      rx_rel_reg <= eng_wr && eng_hit(pointer_reg, `UER_E_RX_CTL)
        && eng_wdata[`UER_BIT_FIFO_RELEASE];
      tx_flush_reg <= eng_wr && eng_hit(pointer_reg, `UER_E_TX_CTL)
        && eng_wdata[`UER_BIT_FIFO_FLUSH];
      tx_push_reg <= eng_wr && eng_hit(pointer_reg, `UER_E_TX_DATA);
      tx_cnt_reg <= eng_wr && eng_hit(pointer_reg, `UER_E_TX_COUNT);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_reg <= 8'h00;
      tx_cnt_val_reg <= 4'h0;
    end else if (eng_wr) begin
      if (eng_hit(pointer_reg, `UER_E_TX_DATA)) begin
        tx_data_reg <= eng_wdata;
      end
      if (eng_hit(pointer_reg, `UER_E_TX_COUNT)) begin
        tx_cnt_val_reg <= eng_wdata[3:0];
      end
    end
  end

  assign rx_fifo_pop_o = rx_pop_reg;
  assign rx_flush_o = rx_flush_reg;
  assign rx_release_o = rx_rel_reg;
  assign tx_flush_o = tx_flush_reg;
  assign tx_push_o = tx_push_reg;
  assign tx_fifo_data_o = tx_data_reg;
  assign tx_count_load_o = tx_cnt_reg;
  assign tx_byte_count_o = tx_cnt_val_reg;

endmodule

// ### verification/uer_props.sv
`timescale 1ns/1ps
module uer_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // cpu port
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire uer_pkg::uer_byte_type cpu_wdata_i,
  input wire uer_pkg::uer_byte_type cpu_rdata_o,
  // engine side
  input wire logic bus_reset_det_i,
  input wire logic host_wakeup_i,
  input wire logic device_suspended_i,
  input wire logic port3_i,
  input wire logic rx_fifo_pop_o,
  input wire logic tx_push_o,
  input wire logic tx_count_load_o,
  // controls
  input wire uer_pkg::uer_func_addr_type function_address_o,
  input wire uer_pkg::uer_ep_type endpoint_select_o,
  input wire logic regulator_enable_o,
  input wire logic osc_enable_o,
  input wire logic cpu_wake_o
);
  import uer_pkg::*;
  logic [1:0] up_reg;
  // skip the first three edges after release, one past the two synchroniser edges
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (up_reg != 2'h3);
  property p_reg;
    cpu_wr_i && cpu_addr_i == 8'he0 |=> regulator_enable_o == $past(cpu_wdata_i[7]);
  endproperty
  a_reg: assert property (p_reg) else $error("regulator bit wrong");
  property p_ptr;
    cpu_wr_i && cpu_addr_i == 8'he1 ##1 cpu_addr_i == 8'he1 |-> cpu_rdata_o == {2'h0, $past(cpu_wdata_i[5:0])};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer high bits set");
  property p_push;
    tx_push_o || tx_count_load_o |-> $past(cpu_wr_i && cpu_addr_i == 8'he2);
  endproperty
  a_push: assert property (p_push) else $error("engine write without data");
  property p_pop;
    rx_fifo_pop_o |-> $past(cpu_wr_i && cpu_addr_i == 8'he0 && cpu_wdata_i[0]);
  endproperty
  a_pop: assert property (p_pop) else $error("pop without read strobe");
  property p_busrst;
    bus_reset_det_i && !cpu_wr_i |=> function_address_o == 7'h00 && endpoint_select_o == 2'h0;
  endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset left state");
  property p_osc;
    osc_enable_o == $past(host_wakeup_i && device_suspended_i);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_wake;
    $fell(port3_i) && device_suspended_i |-> ##[2:5] cpu_wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after pin fall");
  property p_wake1;
    cpu_wake_o |=> !cpu_wake_o;
  endproperty
  a_wake1: assert property (p_wake1) else $error("wake pulse too long");
endmodule

bind uer_top uer_props uer_props_inst (.mclk_i, .arst_n_i, .cpu_addr_i, .cpu_wr_i, .cpu_wdata_i,
  .cpu_rdata_o, .bus_reset_det_i, .host_wakeup_i, .device_suspended_i, .port3_i, .rx_fifo_pop_o,
  .tx_push_o, .tx_count_load_o, .function_address_o, .endpoint_select_o, .regulator_enable_o,
  .osc_enable_o, .cpu_wake_o);

// ### verification/uer_engine_model.sv
`timescale 1ns/1ps
module uer_engine_model (
  // clock and pop
  input wire logic mclk_i,
  input wire logic rx_fifo_pop_o,
  // host-side events and fifo
  output uer_pkg::uer_done_type xact_done_i,
  output logic bus_reset_det_i,
  output logic resume_det_i,
  output logic suspend_det_i,
  output logic host_wakeup_i,
  output logic device_suspended_i,
  output logic port3_i,
  output uer_pkg::uer_byte_type rx_fifo_data_i,
  output uer_pkg::uer_count_type rx_byte_count_i
);
  import uer_pkg::*;
  initial begin
    xact_done_i = 5'h00;
    bus_reset_det_i = 1'b0;
    resume_det_i = 1'b0;
    suspend_det_i = 1'b0;
    host_wakeup_i = 1'b0;
    device_suspended_i = 1'b0;
    port3_i = 1'b1;
    rx_fifo_data_i = 8'h5a;
    rx_byte_count_i = 4'h8;
  end
  // fifo head moves on after every pop
  always @(posedge mclk_i) begin
    if (rx_fifo_pop_o) begin
      rx_fifo_data_i <= rx_fifo_data_i + 8'h01;
    end
  end
  // one-cycle event: 0 bus reset, 1 resume, 2 suspend, else ep3 done
  task automatic pulse(input int k);
    @(posedge mclk_i);
    case (k)
      0: bus_reset_det_i <= 1'b1;
      1: resume_det_i <= 1'b1;
      2: suspend_det_i <= 1'b1;
      default: xact_done_i <= 5'h10;
    endcase
    @(posedge mclk_i);
    bus_reset_det_i <= 1'b0;
    resume_det_i <= 1'b0;
    suspend_det_i <= 1'b0;
    xact_done_i <= 5'h00;
  endtask
  task automatic level(input logic s, input logic w, input logic p);
    @(posedge mclk_i);
    device_suspended_i <= s;
    host_wakeup_i <= w;
    port3_i <= p;
  endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import uer_pkg::*;
  logic mclk_i, arst_n_i, cpu_wr_i, cpu_rd_i;
  logic [7:0] cpu_addr_i;
  uer_byte_type cpu_wdata_i, cpu_rdata_o, tx_fifo_data_o, endpoint_control_o, rx_fifo_data_i, rd;
  uer_done_type xact_done_i;
  uer_count_type rx_byte_count_i, tx_byte_count_o;
  uer_func_addr_type function_address_o;
  uer_ep_type endpoint_select_o;
  logic bus_reset_det_i, resume_det_i, suspend_det_i, host_wakeup_i, device_suspended_i, port3_i;
  logic rx_fifo_pop_o, rx_flush_o, rx_release_o, tx_flush_o, tx_push_o, tx_count_load_o;
  logic regulator_enable_o, test_mode_enable_o, endpoint3_direction_o, minus_line_pullup_enable_o;
  logic connect_release_o, remote_wakeup_trigger_o, osc_enable_o, cpu_wake_o, usb_irq_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  uer_byte_type ev_flag[4] = '{8'h02, 8'h01, 8'h10, 8'h08};
  uer_top uer_top_inst (.mclk_i, .arst_n_i, .cpu_addr_i, .cpu_wr_i, .cpu_rd_i, .cpu_wdata_i,
    .cpu_rdata_o, .xact_done_i, .bus_reset_det_i, .resume_det_i, .suspend_det_i, .host_wakeup_i,
    .device_suspended_i, .port3_i, .rx_fifo_data_i, .rx_byte_count_i, .rx_fifo_pop_o, .rx_flush_o,
    .rx_release_o, .tx_flush_o, .tx_push_o, .tx_fifo_data_o, .tx_count_load_o, .tx_byte_count_o,
    .regulator_enable_o, .test_mode_enable_o, .endpoint3_direction_o, .minus_line_pullup_enable_o,
    .connect_release_o, .function_address_o, .endpoint_select_o, .endpoint_control_o,
    .remote_wakeup_trigger_o, .osc_enable_o, .cpu_wake_o, .usb_irq_o);
  uer_engine_model uer_engine_model_inst (.mclk_i, .rx_fifo_pop_o, .xact_done_i, .bus_reset_det_i,
    .resume_det_i, .suspend_det_i, .host_wakeup_i, .device_suspended_i, .port3_i, .rx_fifo_data_i,
    .rx_byte_count_i);
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input uer_byte_type seen, input uer_byte_type exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input uer_byte_type d);
    @(posedge mclk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    cpu_rd_i <= 1'b0;
    @(posedge mclk_i);
    cpu_wr_i <= 1'b0;
  endtask
  task automatic ewr(input uer_eaddr_type a, input uer_byte_type d);
    wr(8'he1, {2'h0, a});
    wr(8'he0, 8'h02);
    wr(8'he2, d);
    wr(8'he0, 8'h00);
    #1;
  endtask
  task automatic erd(input uer_eaddr_type a, output uer_byte_type d);
    wr(8'he1, {2'h0, a});
    wr(8'he0, 8'h01);
    @(posedge mclk_i);
    cpu_addr_i <= 8'he2;
    cpu_rd_i <= 1'b1;
    #1 d = cpu_rdata_o;
    wr(8'he0, 8'h00);
  endtask
  initial begin
    arst_n_i = 1'b0;
    cpu_wr_i = 1'b0;
    cpu_rd_i = 1'b0;
    cpu_addr_i = 8'h00;
    cpu_wdata_i = 8'h00;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("connect", 8'(connect_release_o), 8'h01);
    erd(6'h01, rd);
    chk("dev_ctl", rd, 8'h01);
    erd(6'h08, rd);
    chk("function_address_reg", rd, 8'h00);
    $display("test reset values done");
    wr(8'he0, 8'h80);
    #1 chk("regulator", 8'(regulator_enable_o), 8'h01);
    chk("access_ctl", cpu_rdata_o, 8'h80);
    wr(8'he0, 8'h00);
    #1 chk("regulator", 8'(regulator_enable_o), 8'h00);
    ewr(6'h01, 8'h06); // test mode kept clear
    chk("ep3_dir", 8'(endpoint3_direction_o), 8'h01);
    chk("pullup", 8'(minus_line_pullup_enable_o), 8'h01);
    chk("connect", 8'(connect_release_o), 8'h00);
    chk("test_mode", 8'(test_mode_enable_o), 8'h00);
    erd(6'h01, rd);
    chk("dev_ctl", rd, 8'h06);
    $display("test device control done");
    ewr(6'h08, 8'h2d);
    wr(8'he2, 8'h7f);
    erd(6'h08, rd);
    chk("function_address_reg", rd, 8'h2d);
    chk("function_address_reg_o", 8'(function_address_o), 8'h2d);
    ewr(6'h31, 8'h03);
    ewr(6'h21, 8'hca);
    chk("ep_sel", 8'(endpoint_select_o), 8'h03);
    chk("ep_ctl", endpoint_control_o, 8'hca);
    ewr(6'h31, 8'h00);
    chk("ep_ctl0", endpoint_control_o, 8'h00);
    $display("test indexed access done");
    ewr(6'h10, 8'h8a);
    ewr(6'h18, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      uer_engine_model_inst.pulse((i + 1) % 4);
      @(posedge mclk_i);
      #1 chk("irq_set", 8'(usb_irq_o), 8'h01);
      erd(i == 2 ? 6'h1a : 6'h12, rd);
      chk("flags", rd, ev_flag[i]);
      ewr(i == 2 ? 6'h1a : 6'h12, i == 2 ? 8'h10 : 8'h00);
      chk("irq_clr", 8'(usb_irq_o), 8'h00);
    end
    chk("function_address_reg_o", 8'(function_address_o), 8'h00);
    $display("test events done");
    erd(6'h23, rd);
    chk("rx0", rd, 8'h5a);
    erd(6'h23, rd);
    chk("rx1", rd, 8'h5b);
    erd(6'h26, rd);
    chk("rx_cnt", rd, 8'h08);
    wr(8'he1, 8'h24);
    wr(8'he0, 8'h02);
    wr(8'he2, 8'h90);
    #1 chk("rx_flush", 8'(rx_flush_o), 8'h01);
    chk("rx_release", 8'(rx_release_o), 8'h01);
    wr(8'he1, 8'h34);
    wr(8'he2, 8'h80);
    #1 chk("tx_flush", 8'(tx_flush_o), 8'h01);
    chk("rx_flush_end", 8'(rx_flush_o), 8'h00);
    wr(8'he1, 8'h33);
    wr(8'he2, 8'ha5);
    #1 chk("tx_push", 8'(tx_push_o), 8'h01);
    chk("tx_data", tx_fifo_data_o, 8'ha5);
    wr(8'he0, 8'h00);
    ewr(6'h36, 8'h05);
    chk("tx_cnt", 8'(tx_byte_count_o), 8'h05);
    $display("test fifo done");
    ewr(6'h12, 8'h20);
    chk("remote_wake", 8'(remote_wakeup_trigger_o), 8'h01);
    uer_engine_model_inst.level(1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge mclk_i);
    #1 chk("osc", 8'(osc_enable_o), 8'h01);
    uer_engine_model_inst.level(1'b1, 1'b0, 1'b0);
    n = 0;
    while (cpu_wake_o !== 1'b1 && n < 8) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("cpu_wake", 8'(cpu_wake_o), 8'h01);
    uer_engine_model_inst.level(1'b0, 1'b0, 1'b1);
    $display("test wake done");
    complete_run();
  end
endmodule
